// ### core/ovl_overlay.sv
`timescale 1ns/1ps

// Notes on behaviour
// - one shared register set, one function active
// - registers reached by memory-mapped access only
// - signed horizontal start from active left edge
// - signed vertical start from active top
// - sprite column preset, ends at column 63
// - sprite row preset, ends at row 63
// - window width in dwords, two bytes
// - window height in rows, two bytes
// - sprite colours masked to display depth
// - sprite enable bit, reset disabled
// - sprite hidden or shown over border
// - pattern byte bit order select
// - blink enable bit, reset off
// - blink period 4 to 32 frames
// - port status mirrors vertical reset, field
// - byte swap of input words
// - word swap of consecutive input words
// - window enable forces sprite off
// - horizontal reduction by 1,2,4,8
// - vertical reduction by 1,2,4,8
// - odd or even line selection
module ovl_overlay (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // memory-mapped register access
  input  wire ovl_pkg::ovl_mmio_s  mmio,
  output logic [7:0]               mmioRdata,
  // display timing
  input  wire ovl_pkg::ovl_disp_s  disp,
  input  wire ovl_pkg::ovl_depth_e depth,
  // sprite pattern planes for current row
  input  wire logic [7:0]          patternPlane0,
  input  wire logic [7:0]          patternPlane1,
  // sprite fetch and pixel
  output logic [23:0]              spriteBase,
  output logic [5:0]               spriteRow,
  output logic [5:0]               spriteCol,
  output logic                     spriteVisible,
  output logic                     spriteInvert,
  output logic [31:0]              spriteColour,
  // window region
  output logic                     windowActive,
  // video port pins
  input  wire logic [15:0]         videoInputBus,
  input  wire logic                videoValidIn,
  input  wire logic                videoLineIn,
  input  wire logic                videoVerticalResetIn_n,
  input  wire logic                videoFieldIn,
  // decimated video out
  output logic [31:0]              videoOutData,
  output logic                     videoOutValid
);

  // register storage
  logic [7:0]  byteReg [ovl_pkg::BYTE_COUNT];
  logic [7:0]  sprCtrl_reg;
  logic [1:0]  portSwap_reg;
  logic [7:0]  winCtrl_reg;

  // pin synchronisers
  logic [15:0] busS1_reg, busS2_reg;
  logic [3:0]  pinS1_reg, pinS2_reg;
  logic        lineDly_reg;

  // decode helpers
  function automatic logic [31:0] depthMask(ovl_pkg::ovl_depth_e d);
    case (d)
      ovl_pkg::OVL_BPP8:  depthMask = 32'h0000_00FF;
      ovl_pkg::OVL_BPP16: depthMask = 32'h0000_FFFF;
      ovl_pkg::OVL_BPP24: depthMask = 32'h00FF_FFFF;
      default:            depthMask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic [3:0] scaleMask(logic [1:0] code);
    case (code)
      2'b00:   scaleMask = 4'h0;
      2'b01:   scaleMask = 4'h1;
      2'b10:   scaleMask = 4'h3;
      default: scaleMask = 4'h7;
    endcase
  endfunction

  function automatic logic [31:0] word32(logic [7:0] ofs);
    logic [4:0] i;
    i = 5'(ofs - ovl_pkg::OFS_X_START);
    word32 = {byteReg[i + 5'd3], byteReg[i + 5'd2], byteReg[i + 5'd1], byteReg[i]};
  endfunction

  // byte registers 80h-93h
  // memory-mapped byte writes
  genvar g;
  generate
    for (g = 0; g < ovl_pkg::BYTE_COUNT; g++) begin : gBytes
      always_ff @(posedge clock) begin
        if (reset) begin
          byteReg[g] <= ovl_pkg::BYTE_RESET;
        end else if (mmio.sel && mmio.write &&
                     mmio.addr == 8'(ovl_pkg::OFS_X_START + 8'(g))) begin
          byteReg[g] <= mmio.wdata;
        end
      end
    end
  endgenerate

  // control registers
  // sprite control resets to 10h
  always_ff @(posedge clock) begin
    if (reset) begin
      sprCtrl_reg  <= ovl_pkg::SPR_CTRL_RESET;
      portSwap_reg <= ovl_pkg::PORT_RESET[7:6];
      winCtrl_reg  <= ovl_pkg::WIN_CTRL_RESET;
    end else if (mmio.sel && mmio.write) begin
      case (mmio.addr)
        ovl_pkg::OFS_SPR_CTRL: sprCtrl_reg  <= {2'b00, mmio.wdata[5:0]};
        ovl_pkg::OFS_PORT:     portSwap_reg <= mmio.wdata[7:6];
        ovl_pkg::OFS_WIN_CTRL: winCtrl_reg  <= mmio.wdata;
        default: ;
      endcase
    end
  end

  // read port
  // live pin levels in status bits
  always_ff @(posedge clock) begin
    if (reset) begin
      mmioRdata <= 8'h00;
    end else if (mmio.sel && !mmio.write) begin
      if (mmio.addr >= ovl_pkg::OFS_X_START && mmio.addr < ovl_pkg::OFS_SPR_CTRL) begin
        mmioRdata <= byteReg[5'(mmio.addr - ovl_pkg::OFS_X_START)];
      end else begin
        case (mmio.addr)
          ovl_pkg::OFS_SPR_CTRL: mmioRdata <= sprCtrl_reg;
          ovl_pkg::OFS_PORT:     mmioRdata <= {portSwap_reg, 4'h0, pinS2_reg[1], pinS2_reg[0]};
          ovl_pkg::OFS_WIN_CTRL: mmioRdata <= winCtrl_reg;
          default:               mmioRdata <= 8'h00;
        endcase
      end
    end
  end

  // decoded fields
  // signed start positions
  logic signed [15:0] xStart, yStart;
  logic [7:0]         xPreset, yPreset;
  logic [15:0]        winWidth, winHeight;
  logic signed [16:0] dx, dy;
  assign xStart  = byteReg[1] == 8'h00 && byteReg[0] == 8'h00 ? 16'sh0000 : $signed({byteReg[1], byteReg[0]});
  assign yStart  = $signed({byteReg[3], byteReg[2]});
  assign xPreset = byteReg[4];
  assign yPreset = byteReg[6];
  assign winWidth  = {byteReg[5], byteReg[4]};
  assign winHeight = {byteReg[7], byteReg[6]};
  assign dx = 17'(disp.x) - 17'(xStart);
  assign dy = 17'(disp.y) - 17'(yStart);

  localparam int ADDR_IDX = int'(ovl_pkg::OFS_SPR_ADDR - ovl_pkg::OFS_X_START);
  assign spriteBase = {byteReg[ADDR_IDX + 2], byteReg[ADDR_IDX + 1], byteReg[ADDR_IDX]};

  // blink timing
  // advance once per frame
  // period 4<<code frames on, same off
  logic [5:0] blinkCnt_reg;
  logic       blinkOn_reg;
  logic [5:0] blinkPeriod;
  assign blinkPeriod = ovl_pkg::BLINK_BASE << sprCtrl_reg[ovl_pkg::SPR_RATE_LO +: 2];
  always_ff @(posedge clock) begin
    if (reset) begin
      blinkCnt_reg <= 6'h00;
      blinkOn_reg  <= 1'b1;
    end else if (disp.frameStart) begin
      if (blinkCnt_reg + 6'h01 >= blinkPeriod) begin
        blinkCnt_reg <= 6'h00;
        blinkOn_reg  <= !blinkOn_reg;
      end else begin
        blinkCnt_reg <= blinkCnt_reg + 6'h01;
      end
    end
  end

  // sprite pixel
  logic [8:0] colIdx, rowIdx;
  logic       inSprite, sprOn, sprShow;
  logic [2:0] bitSel;
  logic [1:0] pixCode;
  // nine bits so a large preset cannot wrap back into the pattern
  assign colIdx = {3'b000, dx[5:0]} + {1'b0, xPreset};
  assign rowIdx = {3'b000, dy[5:0]} + {1'b0, yPreset};
  // start at preset, stop at 63
  assign inSprite = !dx[16] && !dy[16] && dx < 17'sd64 && dy < 17'sd64 &&
                    colIdx <= {1'b0, ovl_pkg::SPR_LAST} && rowIdx <= {1'b0, ovl_pkg::SPR_LAST};
  assign sprOn = sprCtrl_reg[ovl_pkg::SPR_ENABLE] && !winCtrl_reg[ovl_pkg::WIN_ENABLE];
  assign bitSel  = sprCtrl_reg[ovl_pkg::SPR_MSB_1ST] ? 3'(3'd7 - colIdx[2:0]) : colIdx[2:0];
  assign pixCode = {patternPlane1[bitSel], patternPlane0[bitSel]};
  assign sprShow = sprOn && inSprite &&
                   (!disp.inBorder || sprCtrl_reg[ovl_pkg::SPR_OVER_BD]) &&
                   (!sprCtrl_reg[ovl_pkg::SPR_BLINK] || blinkOn_reg);

  always_ff @(posedge clock) begin
    if (reset) begin
      spriteRow     <= 6'h00;
      spriteCol     <= 6'h00;
      spriteVisible <= 1'b0;
      spriteInvert  <= 1'b0;
      spriteColour  <= 32'h0000_0000;
    end else begin
      spriteRow     <= rowIdx[5:0];
      spriteCol     <= colIdx[5:0];
      spriteVisible <= sprShow && !pixCode[1];
      spriteInvert  <= sprShow && pixCode == 2'b11;
      spriteColour  <= (pixCode[0] ? word32(ovl_pkg::OFS_COLOUR1) : word32(ovl_pkg::OFS_COLOUR0))
                       & depthMask(depth);
    end
  end

  // window region, width compared in dwords
  logic [16:0] dxDword;
  always_comb begin
    case (depth)
      ovl_pkg::OVL_BPP8:  dxDword = 17'(dx >>> 2);
      ovl_pkg::OVL_BPP16: dxDword = 17'(dx >>> 1);
      default:            dxDword = dx;
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      windowActive <= 1'b0;
    end else begin
      windowActive <= winCtrl_reg[ovl_pkg::WIN_ENABLE] && !dx[16] && !dy[16] &&
                      dxDword < {1'b0, winWidth} && dy < $signed({1'b0, winHeight});
    end
  end

  // video pin synchronisers
  always_ff @(posedge clock) begin
    if (reset) begin
      busS1_reg   <= 16'h0000;
      busS2_reg   <= 16'h0000;
      pinS1_reg   <= 4'h1;
      pinS2_reg   <= 4'h1;
      lineDly_reg <= 1'b0;
    end else begin
      busS1_reg   <= videoInputBus;
      busS2_reg   <= busS1_reg;
      pinS1_reg   <= {videoLineIn, videoValidIn, videoFieldIn, videoVerticalResetIn_n};
      pinS2_reg   <= pinS1_reg;
      lineDly_reg <= pinS2_reg[3];
    end
  end

  logic        lineEdge, frameReset;
  logic [15:0] wordIn;
  assign lineEdge   = pinS2_reg[3] && !lineDly_reg;
  assign frameReset = !pinS2_reg[0];
  assign wordIn = portSwap_reg[0] ? {busS2_reg[7:0], busS2_reg[15:8]} : busS2_reg;

  // line counter and vertical keep
  logic [7:0] lineCnt_reg;
  logic       lineKeep;
  logic [3:0] vMask;
  // first line edge after a vertical reset lands on line 0
  always_ff @(posedge clock) begin
    if (reset || frameReset) begin
      lineCnt_reg <= 8'hFF;
    end else if (lineEdge) begin
      lineCnt_reg <= lineCnt_reg + 8'h01;
    end
  end
  assign vMask = scaleMask(winCtrl_reg[ovl_pkg::WIN_VSC_LO +: 2]);
  assign lineKeep = (lineCnt_reg[3:0] & vMask) ==
                    ({3'b000, winCtrl_reg[ovl_pkg::WIN_ODD]} & vMask);

  // word pairing and horizontal keep
  logic [15:0] firstWord_reg;
  logic        wordPhase_reg;
  logic [2:0]  hCnt_reg;
  logic        pairDone;
  logic [3:0]  hMask;
  assign pairDone = pinS2_reg[2] && wordPhase_reg;
  assign hMask    = scaleMask(winCtrl_reg[ovl_pkg::WIN_HSC_LO +: 2]);
  always_ff @(posedge clock) begin
    if (reset || lineEdge) begin
      firstWord_reg <= 16'h0000;
      wordPhase_reg <= 1'b0;
      hCnt_reg      <= 3'h0;
    end else if (pinS2_reg[2]) begin
      wordPhase_reg <= !wordPhase_reg;
      if (!wordPhase_reg) begin
        firstWord_reg <= wordIn;
      end else begin
        hCnt_reg <= hCnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      videoOutData  <= 32'h0000_0000;
      videoOutValid <= 1'b0;
    end else begin
      videoOutValid <= pairDone && lineKeep &&
                       (hCnt_reg & hMask[2:0]) == 3'h0;
      videoOutData  <= portSwap_reg[1] ? {firstWord_reg, wordIn} : {wordIn, firstWord_reg};
    end
  end

endmodule

// ### core/ovl_pkg.sv
package ovl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_X_START    = 8'h80;
  localparam logic [7:0] OFS_Y_START    = 8'h82;
  localparam logic [7:0] OFS_XPRE_WLO   = 8'h84;
  localparam logic [7:0] OFS_WIDTH_HI   = 8'h85;
  localparam logic [7:0] OFS_YPRE_HLO   = 8'h86;
  localparam logic [7:0] OFS_HEIGHT_HI  = 8'h87;
  localparam logic [7:0] OFS_SPR_ADDR   = 8'h88;
  localparam logic [7:0] OFS_COLOUR0    = 8'h8C;
  localparam logic [7:0] OFS_COLOUR1    = 8'h90;
  localparam logic [7:0] OFS_SPR_CTRL   = 8'h94;
  localparam logic [7:0] OFS_PORT       = 8'h95;
  localparam logic [7:0] OFS_WIN_CTRL   = 8'h96;
  localparam int         BYTE_COUNT     = 20;

  // reset values
  localparam logic [7:0] SPR_CTRL_RESET = 8'h10;
  localparam logic [7:0] PORT_RESET     = 8'h00;
  localparam logic [7:0] WIN_CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;

  // sprite control fields
  localparam int SPR_ENABLE  = 0;
  localparam int SPR_OVER_BD = 1;
  localparam int SPR_MSB_1ST = 2;
  localparam int SPR_BLINK   = 3;
  localparam int SPR_RATE_LO = 4;

  // port register fields
  localparam int PORT_VRESET = 0;
  localparam int PORT_FIELD  = 1;
  localparam int PORT_BSWAP  = 6;
  localparam int PORT_WSWAP  = 7;

  // window control fields
  localparam int WIN_ENABLE  = 0;
  localparam int WIN_HSC_LO  = 1;
  localparam int WIN_VSC_LO  = 3;
  localparam int WIN_ODD     = 5;

  // sprite geometry and blink base
  localparam logic [7:0] SPR_LAST      = 8'h3F;
  localparam logic [5:0] BLINK_BASE    = 6'h04;

  // display depth codes
  typedef enum logic [1:0] {
    OVL_BPP8,
    OVL_BPP16,
    OVL_BPP24,
    OVL_BPP32
  } ovl_depth_e;

  // memory-mapped byte access
  typedef struct packed {
    logic       sel;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ovl_mmio_s;

  // raster position from the display timing
  typedef struct packed {
    logic               frameStart;
    logic               inBorder;
    logic signed [15:0] x;
    logic signed [15:0] y;
  } ovl_disp_s;

endpackage

// ### tb/ovl_overlay_monitor.sv
`timescale 1ns/1ps
module ovl_overlay_monitor (
  // clock and reset
  input wire logic                clock,
  input wire logic                reset,
  // watched ports
  input wire ovl_pkg::ovl_mmio_s  mmio,
  input wire logic [7:0]          mmioRdata,
  input wire ovl_pkg::ovl_depth_e depth,
  input wire logic [23:0]         spriteBase,
  input wire logic                spriteVisible,
  input wire logic                spriteInvert,
  input wire logic [31:0]         spriteColour,
  input wire logic                windowActive,
  input wire logic                videoVerticalResetIn_n,
  input wire logic                videoFieldIn,
  input wire logic                videoOutValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic rd = mmio.sel && !mmio.write;
  wire logic rdPort = rd && mmio.addr == ovl_pkg::OFS_PORT;
  property p_hold; !rd |=> $stable(mmioRdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_pulse; videoOutValid |=> !videoOutValid; endproperty
  a_pulse: assert property (p_pulse) else $error("output valid longer than one cycle");
  property p_excl; spriteVisible || spriteInvert |-> !windowActive; endproperty
  a_excl: assert property (p_excl) else $error("sprite and window both active");
  property p_rst; $past(reset) |-> !videoOutValid && !spriteVisible && !windowActive; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_m8; depth == ovl_pkg::OVL_BPP8 |=> spriteColour[31:8] == 24'h00_0000; endproperty
  a_m8: assert property (p_m8) else $error("colour not masked to 8 bits");
  property p_m16; depth == ovl_pkg::OVL_BPP16 |=> spriteColour[31:16] == 16'h0000; endproperty
  a_m16: assert property (p_m16) else $error("colour not masked to 16 bits");
  property p_base; mmio.sel && mmio.write && mmio.addr == ovl_pkg::OFS_SPR_ADDR |=>
    spriteBase[7:0] == $past(mmio.wdata); endproperty
  a_base: assert property (p_base) else $error("sprite base low byte not written");
  property p_rsv; rdPort |=> mmioRdata[5:2] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("port reserved bits not zero");
  property p_stat; (!reset && $stable({videoFieldIn, videoVerticalResetIn_n}))[*3] ##0 rdPort |=>
    mmioRdata[1:0] == $past({videoFieldIn, videoVerticalResetIn_n}); endproperty
  a_stat: assert property (p_stat) else $error("port status differs from pins");
  c_video: cover property (videoOutValid);
  c_sprite: cover property (spriteVisible);
  c_window: cover property (windowActive);
endmodule

bind ovl_overlay ovl_overlay_monitor mon (.clock, .reset, .mmio, .mmioRdata, .depth, .spriteBase,
  .spriteVisible, .spriteInvert, .spriteColour, .windowActive, .videoVerticalResetIn_n, .videoFieldIn,
  .videoOutValid);

// ### tb/ovl_video_source.sv
`timescale 1ns/1ps
module ovl_video_source (
  // reference clock
  input wire logic    clock,
  // video port pins
  output logic [15:0] bus,
  output logic        valid,
  output logic        lineStart,
  output logic        vResetN,
  output logic        field
);
  initial begin
    bus = 16'hFFFF;
    valid = 1'b0;
    lineStart = 1'b0;
    vResetN = 1'b1;
    field = 1'b0;
  end
  // frame start with field level
  task automatic frame(input logic f);
    @(posedge clock); #1;
    vResetN = 1'b0;
    field = f;
    @(posedge clock); #1;
    vResetN = 1'b1;
  endtask
  // line of n word pairs from base w
  task automatic line(input int n, input logic [15:0] w);
    lineStart = 1'b1;
    @(posedge clock); #1;
    lineStart = 1'b0;
    for (int k = 0; k < 2 * n; k++) begin
      valid = 1'b1;
      bus = w + 16'(k);
      @(posedge clock); #1;
    end
    valid = 1'b0;
    bus = ~bus;
    repeat (6) @(posedge clock);
    #1;
  endtask
endmodule

// ### tb/test_cursor_and_video_window_overlay.sv
`timescale 1ns/1ps
module test_cursor_and_video_window_overlay;
  logic                clock;
  logic                reset;
  ovl_pkg::ovl_mmio_s  mmio;
  ovl_pkg::ovl_disp_s  disp;
  ovl_pkg::ovl_depth_e depth;
  logic [7:0]          rdata;
  logic [23:0]         base;
  logic [31:0]         colour;
  logic [31:0]         vData;
  logic [15:0]         vBus;
  logic                vis, vValid, vLine, vRstN, vField, vOut;
  logic [7:0]          pat0, pat1;
  logic [5:0]          sRow, sCol;
  logic                inv, winAct;
  int                  fails = 0;
  int                  n_tests = 0;
  int                  cycles = 0;
  logic [31:0]         got[$];
  // addr, write data, read back
  localparam logic [23:0] ROWS [16] = '{24'h80_5A5A, 24'h81_F3F3, 24'h82_7E7E, 24'h83_FFFF, 24'h84_3F3F,
    24'h85_1212, 24'h86_2121, 24'h87_3434, 24'h88_C4C4, 24'h8A_9B9B, 24'h8C_FFFF, 24'h8F_8181,
    24'h94_FF3F, 24'h95_FFC1, 24'h96_3E3E, 24'hA0_5500};
  localparam logic [15:0] SPR [11] = '{16'h8000, 16'h8100, 16'h8200, 16'h8300, 16'h8400, 16'h8600,
    16'h8CFF, 16'h8DFF, 16'h8EFF, 16'h8FFF, 16'h9401};

  ovl_overlay DUT (.clock, .reset, .mmio, .mmioRdata(rdata), .disp, .depth, .patternPlane0(pat0),
    .patternPlane1(pat1), .spriteBase(base), .spriteRow(sRow), .spriteCol(sCol), .spriteVisible(vis),
    .spriteInvert(inv), .spriteColour(colour), .windowActive(winAct), .videoInputBus(vBus), .videoValidIn(vValid),
    .videoLineIn(vLine), .videoVerticalResetIn_n(vRstN), .videoFieldIn(vField), .videoOutData(vData),
    .videoOutValid(vOut));
  ovl_video_source src (.clock, .bus(vBus), .valid(vValid), .lineStart(vLine), .vResetN(vRstN),
    .field(vField));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (vOut === 1'b1) got.push_back(vData);
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude;
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    mmio = '{1'b1, w, a, d};
    @(posedge clock); #1;
    mmio.sel = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic place(input logic signed [15:0] px, input logic signed [15:0] py);
    disp.x = px;
    disp.y = py;
    settle();
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      disp.frameStart = 1'b1;
      @(posedge clock);
      #1;
      disp.frameStart = 1'b0;
      @(posedge clock);
      #1;
    end
    settle();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    @(posedge clock); #1;
    chk("rdata", {24'h00_0000, e}, {24'h00_0000, rdata});
  endtask
  function automatic logic [31:0] swp(input logic [15:0] a, input logic [15:0] b, input int s);
    if (s[0]) begin
      a = {a[7:0], a[15:8]};
      b = {b[7:0], b[15:8]};
    end
    return s[1] ? {a, b} : {b, a};
  endfunction

  initial begin
    reset = 1'b1;
    mmio = '0;
    disp = '0;
    pat0 = 8'h00;
    pat1 = 8'h00;
    depth = ovl_pkg::OVL_BPP8;
    repeat (3) @(posedge clock);
    #1;
    reset = 1'b0;
    rd(ovl_pkg::OFS_SPR_CTRL, ovl_pkg::SPR_CTRL_RESET);
    rd(ovl_pkg::OFS_WIN_CTRL, 8'h00);
    foreach (ROWS[i]) begin
      acc(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], ROWS[i][7:0]);
    end
    chk("base", 32'h009B_00C4, {8'h00, base});
    acc(1'b1, ovl_pkg::OFS_WIN_CTRL, 8'h00);
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, ovl_pkg::OFS_PORT, 8'(s << 6));
      got.delete();
      src.line(1, 16'h1234);
      chk("pair", swp(16'h1234, 16'h1235, s), got[0]);
    end
    acc(1'b1, ovl_pkg::OFS_PORT, 8'h00);
    for (int h = 0; h < 4; h++) begin
      acc(1'b1, ovl_pkg::OFS_WIN_CTRL, 8'(h << 1));
      got.delete();
      src.line(8, 16'h0100);
      chk("hcount", 8 >> h, got.size());
      chk("hfirst", 32'h0101_0100, got[0]);
    end
    for (int v = 1; v < 8; v++) begin
      if (v == 4) continue;
      acc(1'b1, ovl_pkg::OFS_WIN_CTRL, 8'(v << 3));
      src.frame(1'b0);
      for (int ln = 0; ln < 8; ln++) begin
        got.delete();
        src.line(1, 16'h0200);
        chk("vkeep", 32'((ln & ((1 << v[1:0]) - 1)) == int'(v[2])), got.size());
      end
    end
    src.frame(1'b1);
    repeat (3) @(posedge clock);
    #1;
    rd(ovl_pkg::OFS_PORT, 8'h03);
    acc(1'b1, ovl_pkg::OFS_WIN_CTRL, 8'h00);
    foreach (SPR[i]) acc(1'b1, SPR[i][15:8], SPR[i][7:0]);
    repeat (3) @(posedge clock);
    #1;
    chk("visible", 32'h0000_0001, {31'h0, vis});
    chk("colour8", 32'h0000_00FF, colour);
    depth = ovl_pkg::OVL_BPP16;
    repeat (2) @(posedge clock);
    #1;
    chk("colour16", 32'h0000_FFFF, colour);
    acc(1'b1, ovl_pkg::OFS_XPRE_WLO, 8'h3C);
    acc(1'b1, ovl_pkg::OFS_YPRE_HLO, 8'h3E);
    place(16'sd3, 16'sd1);
    chk("lastcol", 32'd63, {26'h0, sCol});
    chk("lastrow", 32'd63, {26'h0, sRow});
    chk("endvis", 32'd1, {31'h0, vis});
    place(16'sd4, 16'sd1);
    chk("colend", 32'd0, {31'h0, vis});
    place(16'sd3, 16'sd2);
    chk("rowend", 32'd0, {31'h0, vis});
    acc(1'b1, ovl_pkg::OFS_XPRE_WLO, 8'hFE);
    place(16'sd2, 16'sd1);
    chk("nowrap", 32'd0, {31'h0, vis});
    acc(1'b1, ovl_pkg::OFS_XPRE_WLO, 8'h00);
    acc(1'b1, ovl_pkg::OFS_YPRE_HLO, 8'h00);
    acc(1'b1, ovl_pkg::OFS_X_START, 8'hFE);
    acc(1'b1, 8'h81, 8'hFF);
    acc(1'b1, ovl_pkg::OFS_Y_START, 8'hFF);
    acc(1'b1, 8'h83, 8'hFF);
    place(16'sd0, 16'sd0);
    chk("negcol", 32'd2, {26'h0, sCol});
    chk("negrow", 32'd1, {26'h0, sRow});
    pat0 = 8'h04;
    pat1 = 8'h04;
    settle();
    chk("invert", 32'd1, {31'h0, inv});
    acc(1'b1, ovl_pkg::OFS_SPR_CTRL, 8'h05);
    settle();
    chk("msbfirst", 32'd0, {31'h0, inv});
    chk("msbvis", 32'd1, {31'h0, vis});
    pat0 = 8'h00;
    pat1 = 8'h00;
    disp.inBorder = 1'b1;
    acc(1'b1, ovl_pkg::OFS_SPR_CTRL, 8'h01);
    settle();
    chk("under", 32'd0, {31'h0, vis});
    acc(1'b1, ovl_pkg::OFS_SPR_CTRL, 8'h03);
    settle();
    chk("over", 32'd1, {31'h0, vis});
    disp.inBorder = 1'b0;
    acc(1'b1, ovl_pkg::OFS_SPR_CTRL, 8'h09);
    frames(3);
    chk("blinkon", 32'd1, {31'h0, vis});
    frames(1);
    chk("blinkoff", 32'd0, {31'h0, vis});
    acc(1'b1, ovl_pkg::OFS_SPR_CTRL, 8'h01);
    acc(1'b1, ovl_pkg::OFS_XPRE_WLO, 8'h02);
    acc(1'b1, ovl_pkg::OFS_WIDTH_HI, 8'h00);
    acc(1'b1, ovl_pkg::OFS_YPRE_HLO, 8'h02);
    acc(1'b1, ovl_pkg::OFS_HEIGHT_HI, 8'h00);
    acc(1'b1, ovl_pkg::OFS_WIN_CTRL, 8'h01);
    settle();
    chk("hidden", 32'h0000_0000, {31'h0, vis});
    chk("window", 32'd1, {31'h0, winAct});
    acc(1'b1, ovl_pkg::OFS_XPRE_WLO, 8'h01);
    settle();
    chk("wideend", 32'd0, {31'h0, winAct});
    acc(1'b1, ovl_pkg::OFS_WIDTH_HI, 8'h01);
    settle();
    chk("widehigh", 32'd1, {31'h0, winAct});
    acc(1'b1, ovl_pkg::OFS_YPRE_HLO, 8'h01);
    settle();
    chk("tallend", 32'd0, {31'h0, winAct});
    conclude();
  end
endmodule
